// ==== qdl_pkg.sv ====
package qdl_pkg;
    // Serial word geometry
    localparam int WORD_BITS   = 24;
    localparam int CODE_BITS   = 16;
    localparam int CHAN_COUNT  = 4;
    localparam int ADDR_HI_POS = 23;
    localparam int ADDR_LO_POS = 22;
    localparam int BCAST_POS   = 21;
    localparam int CODE_MSB    = 15;
    // Reset codes
    localparam logic [15:0] CODE_ZERO_SCALE = 16'h0000;
    localparam logic [15:0] CODE_MID_SCALE  = 16'h8000;
    localparam logic [23:0] SHIFT_RESET     = 24'h000000;

    // Link pins and strobes, raw and after synchronising
    typedef struct packed {
        logic link_clk;
        logic sel_n;
        logic data;
        logic load_n;
        logic update;
        logic rst;
        logic rst_sel;
    } qdl_pins_type;
endpackage

// ==== qdl_serial_load.sv ====
`timescale 1ns/1ps
// Behaviour
// - 24-bit word: addr, broadcast, five ignored, code
// - Five bits after broadcast are ignored
// - Broadcast loads all four input registers
// - Otherwise only the addressed register loads
// - Address 00..11 selects channels A..D
// - Input registers follow load strobe level
// - Update rising edge copies all channels together
// - Update with strobes high writes DAC registers
// - No update or reset rise means the DAC registers hold
// - Reset rise with select low clears zero
// - Reset rise with select high sets mid
// - Shift clock is select OR serial clock
// - Shift on clock rise or select rise
// - Select rise with clock low shifts once
// - Zero code 0000h, mid code 8000h
// - Reset rise leaves shift register unchanged
// - Last shift stage drives serial output
module qdl_serial_load
    import qdl_pkg::*;
(
    // Clock and reset
    input  wire logic        clk,
    input  wire logic        reset_n,
    input  wire logic        clk_en,
    // Serial link pins
    input  wire logic        link_clk,
    input  wire logic        chip_sel_n,
    input  wire logic        serial_in,
    output logic             serial_out,
    // Strobes
    input  wire logic        load_n,
    input  wire logic        update_strobe,
    input  wire logic        dac_reset,
    input  wire logic        reset_value_select,
    // DAC register contents
    output logic [15:0]      dac_code_a,
    output logic [15:0]      dac_code_b,
    output logic [15:0]      dac_code_c,
    output logic [15:0]      dac_code_d
);

    ////////////////////////////////////////////////////////////////////
    // Pin synchronisers
    qdl_pins_type pins_meta_reg;
    qdl_pins_type pins_reg;
    qdl_pins_type pins_last_reg;
    qdl_pins_type pins_raw;

    assign pins_raw = '{link_clk: link_clk, sel_n: chip_sel_n,
                        data: serial_in, load_n: load_n,
                        update: update_strobe, rst: dac_reset,
                        rst_sel: reset_value_select};

    // Two stages, plus a third for edge detection; second and third stages feed logic
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            pins_meta_reg <= '{default: 1'b1};
            pins_reg      <= '{default: 1'b1};
            pins_last_reg <= '{default: 1'b1};
        end else if (clk_en) begin
            pins_meta_reg <= pins_raw;
            pins_reg      <= pins_meta_reg;
            pins_last_reg <= pins_reg;
        end
    end

    ////////////////////////////////////////////////////////////////////
    // Edge detection
    logic shift_clk;
    logic shift_clk_last;
    logic shift_event;
    logic update_rise;
    logic reset_rise;

    assign shift_clk      = pins_reg.sel_n | pins_reg.link_clk;
    assign shift_clk_last = pins_last_reg.sel_n | pins_last_reg.link_clk;
    // Either pin rising while the other is low makes an edge of the OR; select rise counts too
    assign shift_event = shift_clk & ~shift_clk_last;
    assign update_rise = pins_reg.update & ~pins_last_reg.update;
    assign reset_rise  = pins_reg.rst & ~pins_last_reg.rst;

    ////////////////////////////////////////////////////////////////////
    // Shift register, not touched by the reset pin
    logic [23:0] shift_reg;

    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            shift_reg <= SHIFT_RESET;
        end else if (clk_en && shift_event) begin
            shift_reg <= {shift_reg[22:0], pins_reg.data};
        end
    end

    // Daisy chain output from the last stage
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            serial_out <= 1'b0;
        end else if (clk_en) begin
            serial_out <= shift_reg[WORD_BITS-1];
        end
    end

    ////////////////////////////////////////////////////////////////////
    // Word fields; bits 20..16 are never decoded
    logic [1:0]  word_addr;
    logic        word_bcast;
    logic [15:0] word_code;
    logic [15:0] reset_code;

    assign word_addr  = {shift_reg[ADDR_HI_POS], shift_reg[ADDR_LO_POS]};
    assign word_bcast = shift_reg[BCAST_POS];
    assign word_code  = shift_reg[CODE_MSB:0];
    assign reset_code = pins_reg.rst_sel ? CODE_MID_SCALE
                                         : CODE_ZERO_SCALE;

    ////////////////////////////////////////////////////////////////////
    // Input and DAC registers per channel
    logic [15:0] input_reg [CHAN_COUNT];
    logic [15:0] dac_reg   [CHAN_COUNT];

    for (genvar ch = 0; ch < CHAN_COUNT; ch++) begin : g_chan
        logic chan_hit;
        // Broadcast reaches all; else address decode
        assign chan_hit = word_bcast ||
                          (word_addr == 2'(ch));

        // Level-sensitive: follows shift data while load is low.
        // Sampling every clock emulates a transparent latch safely.
        always_ff @(posedge clk or negedge reset_n) begin
            if (!reset_n) begin
                input_reg[ch] <= CODE_ZERO_SCALE;
            end else if (clk_en) begin
                if (reset_rise) begin
                    input_reg[ch] <= reset_code;
                end else if (!pins_reg.load_n && chan_hit) begin
                    input_reg[ch] <= word_code;
                end
            end
        end

        // Edge triggered by update; reset wins over an update
        always_ff @(posedge clk or negedge reset_n) begin
            if (!reset_n) begin
                dac_reg[ch] <= CODE_ZERO_SCALE;
            end else if (clk_en) begin
                if (reset_rise) begin
                    dac_reg[ch] <= reset_code;
                end else if (update_rise) begin
                    dac_reg[ch] <= input_reg[ch];
                end // Holds otherwise
            end
        end
    end

    // Outputs straight from the DAC registers
    assign dac_code_a = dac_reg[0];
    assign dac_code_b = dac_reg[1];
    assign dac_code_c = dac_reg[2];
    assign dac_code_d = dac_reg[3];

    ////////////////////////////////////////////////////////////////////
    // Assertions
    default clocking cb @(posedge clk); endclocking
    default disable iff (!reset_n);

    AST_SHIFT_IN: assert property (clk_en && shift_event |=>
        shift_reg == {$past(shift_reg[22:0]), $past(pins_reg.data)})
        else $error("shift did not take new bit");
    AST_SHIFT_HOLD: assert property (clk_en && !shift_event |=>
        $stable(shift_reg)) else $error("shift changed without edge");
    AST_RESET_KEEPS_SHIFT: assert property (
        clk_en && reset_rise && !shift_event |=> $stable(shift_reg))
        else $error("reset disturbed shift register");
    AST_SEL_RISE_SHIFT: assert property (
        clk_en && pins_reg.sel_n && !pins_last_reg.sel_n
        && !pins_last_reg.link_clk |-> shift_event)
        else $error("select rise did not shift");
    AST_RESET_MID: assert property (
        clk_en && reset_rise && pins_reg.rst_sel |=>
        dac_code_b == 16'h8000 && input_reg[2] == 16'h8000)
        else $error("mid-scale reset wrong");
    AST_RESET_ZERO: assert property (
        clk_en && reset_rise && !pins_reg.rst_sel |=>
        dac_code_d == 16'h0000 && input_reg[0] == 16'h0000)
        else $error("zero reset wrong");
    AST_UPDATE: assert property (
        clk_en && update_rise && !reset_rise |=>
        dac_code_a == $past(input_reg[0]) && dac_code_d == $past(input_reg[3]))
        else $error("update did not copy input registers");
    AST_UPDATE_BC: assert property (
        clk_en && update_rise && !reset_rise |=>
        dac_code_b == $past(input_reg[1]) && dac_code_c == $past(input_reg[2]))
        else $error("update missed channel b or c");
    AST_DAC_HOLD: assert property (
        clk_en && !update_rise && !reset_rise |=> $stable(dac_code_c))
        else $error("DAC register changed without cause");
    AST_LOAD_ADDR: assert property (
        clk_en && !reset_rise && !pins_reg.load_n && !word_bcast
        && word_addr == 2'b01 |=> input_reg[1] == $past(word_code)
        && $stable(input_reg[0])) else $error("addressed load wrong");
    AST_LOAD_OTHERS: assert property (
        clk_en && !reset_rise && !pins_reg.load_n && !word_bcast
        && word_addr == 2'b10 |=> input_reg[2] == $past(word_code)
        && $stable(input_reg[1]) && $stable(input_reg[3]))
        else $error("unaddressed channel changed");
    AST_LOAD_BCAST: assert property (
        clk_en && !reset_rise && !pins_reg.load_n && word_bcast |=>
        input_reg[3] == $past(word_code) && input_reg[0] == $past(word_code))
        else $error("broadcast load wrong");
    AST_SDO: assert property (
        clk_en |=> serial_out == $past(shift_reg[23]))
        else $error("serial out not last stage");
    // A low enable must hold every register, or one pin edge gets acted on more than once
    AST_FREEZE: assert property (
        !clk_en |=> $stable(shift_reg) && $stable(input_reg[2])
        && $stable(dac_code_a) && $stable(serial_out))
        else $error("state moved while enable low");

    // Main scenarios the bench is expected to reach
    COV_BCAST: cover property (!pins_reg.load_n && word_bcast);
    COV_FREEZE: cover property (!clk_en && pins_raw.update);
    COV_UPDATE: cover property (update_rise);
    COV_MID: cover property (reset_rise && pins_reg.rst_sel);
    COV_SEL_SHIFT: cover property (shift_event && !pins_reg.link_clk);

endmodule // qdl_serial_load

// ==== qdl_host_model.sv ====
`timescale 1ns/1ps
module qdl_host_model
    import qdl_pkg::*;
(
    // Clock
    input  wire logic clk,
    // Link and strobe pins
    output logic      link_clk,
    output logic      chip_sel_n,
    output logic      serial_in,
    output logic      load_n,
    output logic      update_strobe
);
    // Idle levels: link clock stands high outside frames
    initial begin
        link_clk = 1'b1;
        chip_sel_n = 1'b1;
        serial_in = 1'b0;
        load_n = 1'b1;
        update_strobe = 1'b0;
    end
    task automatic wait_n(input int n);
        repeat (n) @(negedge clk);
    endtask
    // One 24-bit word, MSB first; tail_low ends with select rising
    // while the link clock is low, which costs one extra shift
    task automatic send_word(input logic [23:0] w, input logic tail_low);
        chip_sel_n = 1'b0;
        wait_n(4);
        for (int i = 23; i >= 0; i--) begin
            link_clk = 1'b0;
            serial_in = w[i];
            wait_n(10);
            link_clk = 1'b1;
            wait_n(10);
        end
        if (tail_low) begin
            link_clk = 1'b0; // breaks the select order on purpose
            wait_n(10);
        end
        chip_sel_n = 1'b1;
        serial_in = ~serial_in; // Released line, not the last bit
        wait_n(6);
        link_clk = 1'b1;
        wait_n(6);
    endtask
    // Load only while no shifting happens
    task automatic load();
        load_n = 1'b0;
        wait_n(8);
        load_n = 1'b1;
        wait_n(4);
    endtask
    task automatic update();
        update_strobe = 1'b1;
        wait_n(8);
        update_strobe = 1'b0;
        wait_n(8);
    endtask
endmodule // qdl_host_model

// ==== qdl_serial_load_tb_top.sv ====
`timescale 1ns/1ps
module qdl_serial_load_tb_top;
    import qdl_pkg::*;
    logic        clk, reset_n, dac_reset, rv_sel, clk_en;
    logic        link_clk, chip_sel_n, serial_in, load_n, upd, ser_out;
    logic [15:0] code_a, code_b, code_c, code_d;
    int          error_cnt = 0, checks_done = 0, cyc = 0;
    qdl_host_model i_qdl_host_model (.clk(clk), .link_clk(link_clk),
        .chip_sel_n(chip_sel_n), .serial_in(serial_in), .load_n(load_n),
        .update_strobe(upd));
    qdl_serial_load i_qdl_serial_load (.clk(clk), .reset_n(reset_n),
        .clk_en(clk_en), .link_clk(link_clk), .chip_sel_n(chip_sel_n),
        .serial_in(serial_in), .serial_out(ser_out), .load_n(load_n),
        .update_strobe(upd), .dac_reset(dac_reset),
        .reset_value_select(rv_sel), .dac_code_a(code_a),
        .dac_code_b(code_b), .dac_code_c(code_c), .dac_code_d(code_d));
    ////////////////////////////////////////////////////////////////////////
    task automatic conclude();
        if (error_cnt == 0 && checks_done > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask
    task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
        checks_done++;
        if (seen !== exp) begin
            error_cnt++;
            $display("CHECK FAILED %0t seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic chk_all(input logic [15:0] a, b, c, d);
        chk(code_a, a);
        chk(code_b, b);
        chk(code_c, c);
        chk(code_d, d);
    endtask
    ////////////////////////////////////////////////////////////////////////
    // Clock, and a cycle ceiling well above the under two thousand needed
    initial begin
        clk = 1'b0;
        forever #4 clk = ~clk;
    end
    always @(posedge clk) begin
        cyc <= cyc + 1;
        if (cyc == 8000) begin
            error_cnt++;
            conclude();
        end
    end
    // Addressed write with junk in the ignored bits, then update
    task automatic t_single();
        i_qdl_host_model.send_word({2'b10, 1'b0, 5'h1f, 16'hbeef}, 1'b0);
        chk({15'h0, ser_out}, 16'h0001);
        i_qdl_host_model.load();
        chk_all(16'h0, 16'h0, 16'h0, 16'h0);
        i_qdl_host_model.update();
        chk_all(16'h0, 16'h0, 16'hbeef, 16'h0);
    endtask
    task automatic t_bcast();
        i_qdl_host_model.send_word({2'b00, 1'b1, 5'h00, 16'h5a5a}, 1'b0);
        i_qdl_host_model.load();
        i_qdl_host_model.update();
        chk_all(16'h5a5a, 16'h5a5a, 16'h5a5a, 16'h5a5a);
    endtask
    // Late select rise shifts once more: address 01 turns into 10,
    // and the released line shifts in the inverse of the last bit.
    // A frozen block must miss the first update pulse entirely.
    task automatic t_extra();
        i_qdl_host_model.send_word(24'h401235, 1'b1);
        i_qdl_host_model.load();
        clk_en = 1'b0;
        i_qdl_host_model.update();
        clk_en = 1'b1;
        i_qdl_host_model.wait_n(4);
        chk_all(16'h5a5a, 16'h5a5a, 16'h5a5a, 16'h5a5a);
        i_qdl_host_model.update();
        chk_all(16'h5a5a, 16'h5a5a, 16'h246a, 16'h5a5a);
    endtask
    // Reset pin rise; a later update must find the input regs reset too
    task automatic t_rst(input logic sel, input logic [15:0] exp);
        rv_sel = sel;
        i_qdl_host_model.wait_n(4);
        dac_reset = 1'b1;
        i_qdl_host_model.wait_n(8);
        dac_reset = 1'b0;
        chk_all(exp, exp, exp, exp);
        i_qdl_host_model.update();
        chk_all(exp, exp, exp, exp);
    endtask
    // Main sequence
    initial begin
        reset_n = 1'b0;
        clk_en = 1'b1;
        dac_reset = 1'b0;
        rv_sel = 1'b0;
        repeat (8) @(negedge clk);
        reset_n = 1'b1;
        repeat (4) @(negedge clk);
        chk_all(16'h0, 16'h0, 16'h0, 16'h0);
        t_single();
        t_bcast();
        t_extra();
        t_rst(1'b1, 16'h8000);
        t_rst(1'b0, 16'h0000);
        conclude();
    end
endmodule // qdl_serial_load_tb_top
